// ### rcr_defs.svh
// Purpose: offsets, field positions and fixed values of the capability bank
// Assumes: 12-bit register window, 32-bit AXI4-Lite data
// Notes:   definitions only
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

`define RCR_ADDR_W          12
`define RCR_DATA_W          32

// byte offsets of the mapped words
`define RCR_VERSION_OFF     12'h000
`define RCR_CAP_LO_OFF      12'h008
`define RCR_CAP_HI_OFF      12'h00c

// version word fields
`define RCR_VER_MINOR_LSB   0
`define RCR_VER_MAJOR_LSB   4
`define RCR_VER_FIELD_W     4

// capability word fields, positions within the 64-bit value
`define RCR_CAP_PSI_BIT     39
`define RCR_CAP_NFR_LSB     40
`define RCR_CAP_NFR_W       8
`define RCR_CAP_ADDRESS_MASK_CEILING_LSB    48
`define RCR_CAP_ADDRESS_MASK_CEILING_W      6
`define RCR_CAP_DWD_BIT     54
`define RCR_CAP_DRD_BIT     55
`define RCR_CAP_GIG_BIT     56
`define RCR_CAP_W           64

// fault slot count limits
`define RCR_SLOTS_W         9
`define RCR_SLOTS_MIN       9'd1
`define RCR_SLOTS_MAX       9'd256

// reset values
`define RCR_CAP_RESET       64'h0000_0000_0000_0000
`define RCR_WORD_RESET      32'h0000_0000
`define RCR_CEIL_UNDEF      6'h00

// AXI response codes
`define RCR_RESP_OKAY       2'b00
`define RCR_RESP_SLVERR     2'b10

`endif

// ### rcr_pkg.sv
// Purpose: types shared by the capability bank modules
// Assumes: constants come from rcr_defs.svh
// Notes:   types only
package rcr_pkg;

    typedef enum logic [1:0] {
        BOOT_HOLD,
        BOOT_SAMPLE,
        BOOT_LIVE
    } rcr_boot_t;

    typedef logic [1:0] rcr_resp_t;

endpackage : rcr_pkg

// ### rcr_axi_rd.sv
// Purpose: AXI4-Lite read channel of the capability bank
// Assumes: lookup_data/lookup_err decode s_araddr combinationally
// Notes:   one read in flight; answer one cycle after address taken
`timescale 1ns/1ps
`include "rcr_defs.svh"

module rcr_axi_rd
    import rcr_pkg::*;
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   enable,
    input  wire logic                   s_arvalid,
    output logic                        s_arready,
    output logic [`RCR_DATA_W-1:0]      s_rdata,
    output rcr_resp_t                   s_rresp,
    output logic                        s_rvalid,
    input  wire logic                   s_rready,
    input  wire logic [`RCR_DATA_W-1:0] lookup_data,
    input  wire logic                   lookup_err
);

    logic                   arready_q, arready_d;
    logic                   rvalid_q,  rvalid_d;
    logic [`RCR_DATA_W-1:0] rdata_q,   rdata_d;
    rcr_resp_t              rresp_q,   rresp_d;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = lookup_data;
            rresp_d  = lookup_err ? `RCR_RESP_SLVERR : `RCR_RESP_OKAY;
        end
        // no new address while an answer waits
        arready_d = enable && !rvalid_d;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= `RCR_WORD_RESET;
            rresp_q   <= `RCR_RESP_OKAY;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    assign s_arready = arready_q;
    assign s_rvalid  = rvalid_q;
    assign s_rdata   = rdata_q;
    assign s_rresp   = rresp_q;

endmodule : rcr_axi_rd

// ### rcr_axi_wr.sv
// Purpose: AXI4-Lite write channels of the capability bank
// Assumes: aw_hit decodes s_awaddr combinationally
// Notes:   data is discarded; only the response reflects the address
`timescale 1ns/1ps
`include "rcr_defs.svh"

module rcr_axi_wr
    import rcr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic enable,
    input  wire logic s_awvalid,
    output logic      s_awready,
    input  wire logic s_wvalid,
    output logic      s_wready,
    output rcr_resp_t s_bresp,
    output logic      s_bvalid,
    input  wire logic s_bready,
    input  wire logic aw_hit
);

    logic      awready_q, awready_d;
    logic      wready_q,  wready_d;
    logic      aw_held_q, aw_held_d;
    logic      w_held_q,  w_held_d;
    logic      hit_q,     hit_d;
    logic      bvalid_q,  bvalid_d;
    rcr_resp_t bresp_q,   bresp_d;

    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        hit_d     = hit_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (bvalid_q && s_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_held_q && w_held_q && !bvalid_q) begin
            bvalid_d  = 1'b1;
            bresp_d   = hit_q ? `RCR_RESP_OKAY : `RCR_RESP_SLVERR;
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
        end
        // address and data may arrive in either order
        if (s_awvalid && awready_q) begin
            aw_held_d = 1'b1;
            hit_d     = aw_hit;
        end
        if (s_wvalid && wready_q) begin
            w_held_d = 1'b1;
        end
        awready_d = enable && !aw_held_d && !bvalid_d;
        wready_d  = enable && !w_held_d && !bvalid_d;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            hit_q     <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RCR_RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            hit_q     <= hit_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_awready = awready_q;
    assign s_wready  = wready_q;
    assign s_bvalid  = bvalid_q;
    assign s_bresp   = bresp_q;

endmodule : rcr_axi_wr

// ### rcr_top.sv
// Purpose: read-only version and capability reporting for a remapping unit
// Assumes: strap pins are stable around reset release
// Notes:   straps are caught once; later changes are not seen until reset
`timescale 1ns/1ps
`include "rcr_defs.svh"

// Operation
// - version word at 000h, upper bits zero
// - major revision in version bits 7:4
// - minor revision in version bits 3:0
// - 64-bit capability at 008h, 63:57 zero
// - bit 56 reports first-level gigabyte pages
// - bit 55 reports read draining support
// - bit 54 reports write draining support
// - address-space support forces both drain bits
// - bits 53:48 give largest address mask
// - mask ceiling meaningful only with page-selective
// - address-space support accepts every address mask
// - fault slot count reported minus one
// - slots in bits 47:40, between 1 and 256
// - bit 39 reports page-selective invalidation
module rcr_top
    import rcr_pkg::*;
#(
    parameter logic [`RCR_VER_FIELD_W-1:0] VER_MAJOR = 4'h3, // arbitrary
    parameter logic [`RCR_VER_FIELD_W-1:0] VER_MINOR = 4'h2  // arbitrary
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // strap pins, caught after reset release
    input  wire logic                   strap_gig_page,
    input  wire logic                   strap_read_drain,
    input  wire logic                   strap_write_drain,
    input  wire logic                   strap_process_address_space_support,
    input  wire logic                   strap_psi,
    input  wire logic [5:0]             strap_mask_ceiling,
    input  wire logic [8:0]             strap_fault_slots,
    // AXI4-Lite slave
    input  wire logic [`RCR_ADDR_W-1:0] s_awaddr,
    input  wire logic                   s_awvalid,
    output logic                        s_awready,
    input  wire logic [`RCR_DATA_W-1:0] s_wdata,
    input  wire logic                   s_wvalid,
    output logic                        s_wready,
    output rcr_resp_t                   s_bresp,
    output logic                        s_bvalid,
    input  wire logic                   s_bready,
    input  wire logic [`RCR_ADDR_W-1:0] s_araddr,
    input  wire logic                   s_arvalid,
    output logic                        s_arready,
    output logic [`RCR_DATA_W-1:0]      s_rdata,
    output rcr_resp_t                   s_rresp,
    output logic                        s_rvalid,
    input  wire logic                   s_rready,
    // capability state toward the rest of the unit
    output logic                        caps_live_q,
    output logic                        ext_inval_any_mask_q,
    output logic [8:0]                  fault_slot_count_q
);

    rcr_boot_t                  boot_q, boot_d;
    logic [`RCR_CAP_W-1:0]      cap_q, cap_d;
    logic                       live_q, live_d;
    logic                       any_mask_q, any_mask_d;
    logic [`RCR_SLOTS_W-1:0]    slots_q, slots_d;
    logic [`RCR_DATA_W-1:0]     version_word;
    logic [`RCR_DATA_W-1:0]     rd_lookup;
    logic                       rd_err;
    logic                       aw_hit;
    logic [`RCR_SLOTS_W-1:0]    slots_clamped;

    // boot sequence: one cycle in HOLD after release, then the straps are caught at the end of SAMPLE
    always_comb begin
        boot_d = boot_q;
        case (boot_q)
            BOOT_HOLD:   boot_d = BOOT_SAMPLE;
            BOOT_SAMPLE: boot_d = BOOT_LIVE;
            BOOT_LIVE:   boot_d = BOOT_LIVE;
            default:     boot_d = BOOT_HOLD;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boot_q <= BOOT_HOLD;
        end else begin
            boot_q <= boot_d;
        end
    end

    // out-of-range strap counts are pulled back inside the legal range
    always_comb begin
        if (strap_fault_slots < `RCR_SLOTS_MIN) begin
            slots_clamped = `RCR_SLOTS_MIN;
        end else if (strap_fault_slots > `RCR_SLOTS_MAX) begin
            slots_clamped = `RCR_SLOTS_MAX;
        end else begin
            slots_clamped = strap_fault_slots;
        end
    end

    // capability word composed from the straps, held after sampling
    always_comb begin
        logic [`RCR_SLOTS_W-1:0] enc;
        enc        = slots_clamped - `RCR_SLOTS_MIN;
        cap_d      = cap_q;
        live_d     = live_q;
        any_mask_d = any_mask_q;
        slots_d    = slots_q;
        if (boot_q == BOOT_SAMPLE) begin
            cap_d = `RCR_CAP_RESET;
            cap_d[`RCR_CAP_GIG_BIT] = strap_gig_page;
            // address-space support needs both drain kinds
            cap_d[`RCR_CAP_DRD_BIT] = strap_read_drain | strap_process_address_space_support;
            cap_d[`RCR_CAP_DWD_BIT] = strap_write_drain | strap_process_address_space_support;
            // ceiling has no meaning without page-selective; report zero
            cap_d[`RCR_CAP_ADDRESS_MASK_CEILING_LSB +: `RCR_CAP_ADDRESS_MASK_CEILING_W] =
                strap_psi ? strap_mask_ceiling : `RCR_CEIL_UNDEF;
            cap_d[`RCR_CAP_NFR_LSB +: `RCR_CAP_NFR_W] =
                enc[`RCR_CAP_NFR_W-1:0];
            cap_d[`RCR_CAP_PSI_BIT] = strap_psi;
            any_mask_d = strap_process_address_space_support;
            slots_d    = slots_clamped;
            live_d     = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cap_q      <= `RCR_CAP_RESET;
            live_q     <= 1'b0;
            any_mask_q <= 1'b0;
            slots_q    <= `RCR_SLOTS_MIN;
        end else begin
            cap_q      <= cap_d;
            live_q     <= live_d;
            any_mask_q <= any_mask_d;
            slots_q    <= slots_d;
        end
    end

    // version word: revision nibbles only, everything above reads zero
    always_comb begin
        version_word = `RCR_WORD_RESET;
        version_word[`RCR_VER_MAJOR_LSB +: `RCR_VER_FIELD_W] =
            VER_MAJOR;
        version_word[`RCR_VER_MINOR_LSB +: `RCR_VER_FIELD_W] =
            VER_MINOR;
    end

    // read decode; low address bits select within the word and are ignored
    always_comb begin
        rd_lookup = `RCR_WORD_RESET;
        rd_err    = 1'b0;
        if ({s_araddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_VERSION_OFF) begin
            rd_lookup = version_word;
        end else if ({s_araddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_CAP_LO_OFF)
        begin
            rd_lookup = cap_q[31:0];
        end else if ({s_araddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_CAP_HI_OFF)
        begin
            rd_lookup = cap_q[63:32];
        end else begin
            rd_err = 1'b1;
        end
    end

    // write decode only chooses the answer; stored state never changes
    always_comb begin
        if ({s_awaddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_VERSION_OFF) begin
            aw_hit = 1'b1;
        end else if ({s_awaddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_CAP_LO_OFF)
        begin
            aw_hit = 1'b1;
        end else if ({s_awaddr[`RCR_ADDR_W-1:2], 2'b00} == `RCR_CAP_HI_OFF)
        begin
            aw_hit = 1'b1;
        end else begin
            aw_hit = 1'b0;
        end
    end

    // bus held off until the straps are caught, so no stale read escapes
    rcr_axi_rd u_rd (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .enable      (live_q),
        .s_arvalid   (s_arvalid),
        .s_arready   (s_arready),
        .s_rdata     (s_rdata),
        .s_rresp     (s_rresp),
        .s_rvalid    (s_rvalid),
        .s_rready    (s_rready),
        .lookup_data (rd_lookup),
        .lookup_err  (rd_err)
    );

    // write data is taken and dropped
    rcr_axi_wr u_wr (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .enable    (live_q),
        .s_awvalid (s_awvalid),
        .s_awready (s_awready),
        .s_wvalid  (s_wvalid),
        .s_wready  (s_wready),
        .s_bresp   (s_bresp),
        .s_bvalid  (s_bvalid),
        .s_bready  (s_bready),
        .aw_hit    (aw_hit)
    );

    assign caps_live_q          = live_q;
    assign ext_inval_any_mask_q = any_mask_q;
    assign fault_slot_count_q   = slots_q;

endmodule : rcr_top

// ### rcr_top_chk.sv
// Purpose: port-level checks of the capability bank
// Assumes: read answer comes one cycle after the address is taken
// Notes:   word address of the read in flight is tracked locally
`timescale 1ns/1ps
`include "rcr_defs.svh"

module rcr_top_chk
    import rcr_pkg::*;
#(
    parameter logic [`RCR_VER_FIELD_W-1:0] VER_MAJOR = 4'h3,
    parameter logic [`RCR_VER_FIELD_W-1:0] VER_MINOR = 4'h2
)
(
    input wire logic                   ref_clk,
    input wire logic                   rst,
    input wire logic                   s_awvalid,
    input wire logic                   s_awready,
    input wire logic                   s_wvalid,
    input wire logic                   s_wready,
    input wire rcr_resp_t              s_bresp,
    input wire logic                   s_bvalid,
    input wire logic                   s_bready,
    input wire logic [`RCR_ADDR_W-1:0] s_araddr,
    input wire logic                   s_arvalid,
    input wire logic                   s_arready,
    input wire logic [`RCR_DATA_W-1:0] s_rdata,
    input wire rcr_resp_t              s_rresp,
    input wire logic                   s_rvalid,
    input wire logic                   s_rready,
    input wire logic                   caps_live_q,
    input wire logic                   ext_inval_any_mask_q,
    input wire logic [8:0]             fault_slot_count_q
);
    logic [9:0] rd_word_q;
    logic [9:0] rd_word_d;
    logic       hi_rd;

    always_comb begin
        rd_word_d = rd_word_q;
        if (s_arvalid && s_arready) begin
            rd_word_d = s_araddr[11:2];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_word_q <= 10'h000;
        end else begin
            rd_word_q <= rd_word_d;
        end
    end

    // upper capability word is the one holding every reported field
    assign hi_rd = s_rvalid && (rd_word_q == 10'h003);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_ver_word: assert property (
        s_rvalid && rd_word_q == 10'h000
        |-> s_rdata == {24'h000000, VER_MAJOR, VER_MINOR})
        else $error("version word wrong");
    a_cap_rsvd: assert property (
        hi_rd |-> s_rdata[31:25] == 7'h00) else $error("reserved bits set");
    a_drain_forced: assert property (
        hi_rd && ext_inval_any_mask_q |-> s_rdata[23:22] == 2'b11)
        else $error("drain bits not forced");
    a_slot_encode: assert property (
        hi_rd |-> s_rdata[15:8] == 8'(fault_slot_count_q - 9'h001))
        else $error("slot count encoding wrong");
    a_slot_range: assert property (
        caps_live_q |-> fault_slot_count_q inside {[9'h001:9'h100]})
        else $error("slot count out of range");
    a_ceil_hidden: assert property (
        hi_rd && !s_rdata[7] |-> s_rdata[21:16] == 6'h00)
        else $error("mask ceiling shown without page-selective");
    a_caps_frozen: assert property (
        caps_live_q && $past(caps_live_q)
        |-> $stable(fault_slot_count_q) && $stable(ext_inval_any_mask_q))
        else $error("capability state changed");
    a_read_answer: assert property (
        s_arvalid && s_arready |=> s_rvalid && !s_arready)
        else $error("read answer missing");
    a_rdata_hold: assert property (
        s_rvalid && !s_rready
        |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
        else $error("read answer not held");
    a_bus_gated: assert property (
        s_arready || s_awready |-> caps_live_q)
        else $error("bus open before straps caught");
    a_b_after_both: assert property (
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response not held");
endmodule : rcr_top_chk

bind rcr_top rcr_top_chk #(.VER_MAJOR(VER_MAJOR), .VER_MINOR(VER_MINOR))
    u_rcr_top_chk (.ref_clk(ref_clk), .rst(rst), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .caps_live_q(caps_live_q),
    .ext_inval_any_mask_q(ext_inval_any_mask_q),
    .fault_slot_count_q(fault_slot_count_q));

// ### tb_top.sv
// Purpose: self-checking bench of the capability bank over AXI4-Lite
// Assumes: straps change only while reset is held
// Notes:   strap vector {gig,rd,wd,process_address_space_support,psi,mask[5:0],slots[8:0]}
`timescale 1ns/1ps
`include "rcr_defs.svh"

module tb_top
    import rcr_pkg::*;
;
    localparam logic [3:0] VMAJ = 4'h5; // arbitrary
    localparam logic [3:0] VMIN = 4'h7; // arbitrary
    logic        ref_clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [19:0] straps;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic        awready, wready, bvalid, arready, rvalid, live, any_mask;
    logic [8:0]  slots;
    rcr_resp_t   bresp, rresp, r;
    int          n_mismatch = 0;
    int          num_checks = 0;

    rcr_top #(.VER_MAJOR(VMAJ), .VER_MINOR(VMIN)) u_rcr_top (
        .ref_clk(ref_clk), .rst(rst), .strap_gig_page(straps[19]),
        .strap_read_drain(straps[18]), .strap_write_drain(straps[17]),
        .strap_process_address_space_support(straps[16]), .strap_psi(straps[15]),
        .strap_mask_ceiling(straps[14:9]), .strap_fault_slots(straps[8:0]),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
        .s_wdata(wdata), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready), .caps_live_q(live),
        .ext_inval_any_mask_q(any_mask), .fault_slot_count_q(slots));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function logic [8:0] exp_slots(input logic [19:0] c);
        if (c[8:0] == 9'h000) return 9'h001;
        if (c[8:0] > 9'h100) return 9'h100;
        return c[8:0];
    endfunction : exp_slots

    function logic [31:0] exp_hi(input logic [19:0] c);
        return {7'h00, c[19], c[18] | c[16], c[17] | c[16],
                c[15] ? c[14:9] : 6'h00, 8'(exp_slots(c) - 9'h001),
                c[15], 7'h00};
    endfunction : exp_hi

    task reset_dut(input logic [19:0] cfg);
        @(posedge ref_clk);
        straps <= cfg;
        rst    <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rst    <= 1'b0;
    endtask : reset_dut

    // waits have no limit of their own; the watchdog ends a hang
    task axi_read(input logic [11:0] a, input int stall);
        @(posedge ref_clk);
        arvalid <= 1'b1;
        araddr  <= a;
        do begin
            @(posedge ref_clk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        araddr  <= ~a;
        repeat (stall) @(posedge ref_clk);
        rready <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task axi_write(input logic [11:0] a, input int stall);
        bit aw, w;
        @(posedge ref_clk);
        {awvalid, wvalid} <= 2'b11;
        awaddr <= a;
        wdata  <= 32'hffff_ffff;
        aw = 1'b0;
        w  = 1'b0;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end while (!(aw && w));
        repeat (stall) @(posedge ref_clk);
        bready <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task t_version;
        axi_read(12'h000, 0);
        check(d, {24'h000000, VMAJ, VMIN});
        check(32'(r), 32'(`RCR_RESP_OKAY));
    endtask : t_version

    task t_caps(input logic [19:0] cfg);
        reset_dut(cfg);
        axi_read(12'h00c, 2);
        check(d, exp_hi(cfg));
        axi_read(12'h008, 0);
        check(d, 32'h0000_0000);
        check({23'h0, slots}, {23'h0, exp_slots(cfg)});
        check({31'h0, any_mask}, {31'h0, cfg[16]});
        check({31'h0, live}, 32'h0000_0001);
    endtask : t_caps

    // writes must leave the upper capability and version words as they were; unmapped places refuse
    task t_write_ignored(input logic [19:0] cfg);
        axi_write(12'h00c, 3);
        check(32'(r), 32'(`RCR_RESP_OKAY));
        axi_write(12'h000, 0);
        check(32'(r), 32'(`RCR_RESP_OKAY));
        axi_write(12'h004, 0);
        check(32'(r), 32'(`RCR_RESP_SLVERR));
        axi_read(12'h00c, 0);
        check(d, exp_hi(cfg));
        axi_read(12'h004, 0);
        check(32'(r), 32'(`RCR_RESP_SLVERR));
        check(d, 32'h0000_0000);
        t_version();
    endtask : t_write_ignored

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'b100000;
        {straps, awaddr, araddr, wdata} = '0;
        t_caps(20'h00000);
        t_version();
        t_caps(20'heff00);
        t_write_ignored(20'heff00);
        t_caps(20'h1552c);
        t_caps(20'h29205);
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_top
